// ### core/pwm_params.svh
// Purpose: offsets, field positions and reset values of the pwm timer
// Assumes: byte addresses on an 8-bit apb address, one word each
// Notes: field macros expand to bit ranges or bit numbers
`ifndef PWM_PARAMS_SVH
`define PWM_PARAMS_SVH
// register word indices (byte address is four times these)
`define IX_CTRL 4'h0
`define IX_PSC 4'h1
`define IX_ARR 4'h2
`define IX_REP 4'h3
`define IX_CMP0 4'h4
`define IX_CMP1 4'h5
`define IX_CMP2 4'h6
`define IX_CMP3 4'h7
`define IX_PROT 4'h8
`define IX_OUT 4'h9
`define IX_STAT 4'hA
`define IX_IEN 4'hB
`define IX_CNT 4'hC
`define IX_DCFG 4'hD
`define IX_DDATA 4'hE
`define IX_LAST 4'hE
// control fields
`define C_EN 0
`define C_CENTER 1
`define C_OVF 2
`define C_UNF 3
`define C_PRELOAD 4
`define C_SAFE 5
`define C_DMA 6
`define C_CUP 7
`define C_CDN 8
// protection fields
`define P_DT 7:0
`define P_LOCK 9:8
`define P_FEN 10
`define P_FPOL 11
`define P_AUTO 12
`define P_GATE 13
`define P_CSS 14
// output config, status, dma config fields
`define O_IDLE 5:0
`define O_POL 8:6
`define S_UPD 0
`define S_BRK 5
`define S_TRG 6
`define D_BASE 3:0
`define D_LEN 7:4
// reset values
`define CTRL_RST 9'h190
`define ARR_RST 16'hFFFF
`define LOCK_OFF 2'h0
`define LOCK_ALL 2'h3
`endif

// ### core/pwm_pkg.sv
// Purpose: types shared by the pwm timer modules
// Assumes: nothing beyond the params header
// Notes: state of each module lives in one packed struct
package pwm_pkg;
  typedef enum logic {DIR_UP = 1'b0, DIR_DOWN = 1'b1} dir_type;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_type;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_type;
  typedef struct packed {
    logic [2:0] s1;
    logic [2:0] s2;
    logic [2:0] s3;
    logic [2:0] val;
  } sync_state_type;
  typedef struct packed {
    logic ref_q;
    logic [9:0] cnt;
    logic hi;
    logic lo;
  } dead_state_type;
  typedef struct packed {
    logic [8:0] ctrl;
    logic [15:0] psc_pre;
    logic [15:0] psc_act;
    logic [15:0] psc_cnt;
    logic [15:0] arr_pre;
    logic [15:0] arr_act;
    logic [7:0] rep;
    logic [7:0] rep_cnt;
    logic [3:0][15:0] cmp_pre;
    logic [3:0][15:0] cmp_act;
    logic [15:0] cnt;
    dir_type dir;
    logic [7:0] dt;
    logic [1:0] lock;
    logic lock_done;
    logic fen;
    logic fpol;
    logic auto;
    logic gate;
    logic cssen;
    logic [5:0] idle;
    logic [2:0] pol;
    logic [6:0] status;
    logic [6:0] irq_en;
    logic [3:0] dbase;
    logic [3:0] dlen;
    logic [3:0] dptr;
    logic trg_q;
    logic dma_q;
    logic [31:0] prdata;
  } state_type;
  // dead time code to clock cycles, finer steps at the low end
  function automatic logic [9:0] dead_cycles(input logic [7:0] g);
    logic [9:0] r;
    r = 10'h000;
    if (!g[7])
      r = {3'h0, g[6:0]};
    else if (!g[6])
      r = {2'h0, 1'b1, g[5:0], 1'b0};
    else if (!g[5])
      r = {1'b0, 1'b1, g[4:0], 3'h0};
    else
      r = {1'b1, g[4:0], 4'h0};
    return r;
  endfunction
endpackage

// ### core/sync3.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: inputs are levels from outside the pclk domain
// Notes: a change is taken once stages two and three agree
`timescale 1ns/100ps
module sync3 (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [2:0] async_in,
  output logic [2:0] sync_out
);
  pwm_pkg::sync_state_type s_q;
  pwm_pkg::sync_state_type s_d;

  // first stage feeds only the second stage
  always_comb begin
    s_d = s_q;
    s_d.s1 = async_in;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    s_d.val = (s_q.s2 & s_q.s3) | (s_q.val & (s_q.s2 | s_q.s3));
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign sync_out = s_q.val;
endmodule

// ### core/dead_time_pair.sv
// Purpose: complementary pair with dead time on every edge
// Assumes: dead count stable across a switching gap
// Notes: both sides low during the gap, even with zero dead time
`timescale 1ns/100ps
module dead_time_pair (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ref_in,
  input wire logic [9:0] dead,
  output logic high_out,
  output logic low_out
);
  pwm_pkg::dead_state_type s_q;
  pwm_pkg::dead_state_type s_d;

  // an edge drops both sides, turn-on waits for the count
  always_comb begin
    s_d = s_q;
    if (ref_in != s_q.ref_q) begin
      s_d.ref_q = ref_in;
      s_d.hi = 1'b0;
      s_d.lo = 1'b0;
      s_d.cnt = dead;
    end else if (s_q.cnt != 10'h000) begin
      s_d.cnt = s_q.cnt - 10'h001;
    end else begin
      s_d.hi = s_q.ref_q;
      s_d.lo = ~s_q.ref_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign high_out = s_q.hi;
  assign low_out = s_q.lo;

  a_pair_overlap: assert property (@(posedge pclk) disable iff (!presetn)
    !(s_q.hi && s_q.lo)) else $error("both sides of pair on");
endmodule

// ### core/motor_pwm_timer_protect.sv
// Purpose: motor pwm timer with dead time, break and lock
// Assumes: apb master as published, zero wait states here
// Notes: emergency shutdown path to pwm_out is combinational
// Summary of operation
// - update event copies all preloads together
// - preload off makes compare writes immediate
// - new period at update keeps duty settings
// - 8-bit repetition counter divides update rate
// - center mode updates on overflow, underflow, both
// - both selected gives double update per period
// - edge or center aligned counting selectable
// - status flags for compare, trigger, break
// - burst data port writes consecutive registers
// - 8-bit non-linear dead time code
// - fault input forces outputs idle combinationally
// - break from fault pin or clock monitor
// - break clears gate, sets flag, may interrupt
// - break drives each output to idle level
// - without auto, gate stays low until written
// - with auto, gate returns at next update
// - protected settings read-only once locked
// - lock field is write-once until reset
// - four lock levels protect growing sets
// - normal debug mode keeps running when halted
// - safe mode freezes counter and shuts outputs
//
// The implementer's own choices: the address map and register access over APB.
`timescale 1ns/100ps
`include "pwm_params.svh"
module motor_pwm_timer_protect (
  input wire logic pclk,
  input wire logic presetn,
  input pwm_pkg::apb_req_type apb_req,
  output pwm_pkg::apb_rsp_type apb_rsp,
  input wire logic fault_shutdown_input,
  input wire logic clock_security_fault,
  input wire logic debug_halt,
  input wire logic external_trigger_input,
  output logic [5:0] pwm_out,
  output logic irq,
  output logic dma_req
);
  pwm_pkg::state_type s_q;
  pwm_pkg::state_type s_d;
  logic [3:0] idx;
  logic bad;
  logic wr;
  logic step;
  logic ovf;
  logic unf;
  logic per_evt;
  logic upd;
  logic tick;
  logic [6:0] hw_set;
  logic raw_break;
  logic [2:0] sync_val;
  logic brk_s;
  logic halt_s;
  logic trg_s;
  logic frozen;
  logic force_idle;
  logic [2:0] ref_w;
  logic [2:0] hi_w;
  logic [2:0] lo_w;
  logic [5:0] pair_out;
  logic [9:0] dead_w;

  // software write of one register, lock level masks protected fields
  function automatic pwm_pkg::state_type reg_write(
    input pwm_pkg::state_type s,
    input logic [3:0] ix,
    input logic [31:0] wd
  );
    pwm_pkg::state_type r;
    r = s;
    case (ix)
      `IX_CTRL: begin
        r.ctrl = wd[8:0];
        if (s.lock == `LOCK_ALL) begin
          r.ctrl[`C_CENTER] = s.ctrl[`C_CENTER];
          r.ctrl[`C_OVF] = s.ctrl[`C_OVF];
          r.ctrl[`C_UNF] = s.ctrl[`C_UNF];
        end
      end
      `IX_PSC: r.psc_pre = wd[15:0];
      `IX_ARR: r.arr_pre = wd[15:0];
      `IX_REP: r.rep = wd[7:0];
      `IX_CMP0, `IX_CMP1, `IX_CMP2, `IX_CMP3: begin
        r.cmp_pre[ix[1:0]] = wd[15:0];
        if (!s.ctrl[`C_PRELOAD])
          r.cmp_act[ix[1:0]] = wd[15:0];
      end
      `IX_PROT: begin
        r.gate = wd[`P_GATE];
        if (s.lock == `LOCK_OFF) begin
          r.dt = wd[`P_DT];
          r.fen = wd[`P_FEN];
          r.fpol = wd[`P_FPOL];
          r.auto = wd[`P_AUTO];
          r.cssen = wd[`P_CSS];
        end
        if (!s.lock_done) begin
          r.lock = wd[`P_LOCK];
          r.lock_done = 1'b1;
        end
      end
      `IX_OUT: begin
        if (s.lock == `LOCK_OFF)
          r.idle = wd[`O_IDLE];
        if (s.lock < 2'h2)
          r.pol = wd[`O_POL];
      end
      `IX_STAT: r.status = s.status & ~wd[6:0];
      `IX_IEN: r.irq_en = wd[6:0];
      `IX_DCFG: begin
        r.dbase = wd[`D_BASE];
        r.dlen = wd[`D_LEN];
        r.dptr = 4'h0;
      end
      default: ;
    endcase
    return r;
  endfunction

  // apb decode, zero wait states, unmapped words answer with an error
  assign idx = apb_req.paddr[5:2];
  assign bad = (apb_req.paddr[1:0] != 2'h0) |
    (apb_req.paddr[7:6] != 2'h0) | (idx > `IX_LAST);
  assign apb_rsp.pready = 1'b1;
  assign apb_rsp.pslverr = apb_req.psel & apb_req.penable & bad;
  assign apb_rsp.prdata = s_q.prdata;
  assign wr = apb_req.psel & apb_req.penable & apb_req.pwrite & ~bad;

  // pin levels: fault with polarity and enable, or clock monitor
  assign raw_break = (s_q.fen & ~(fault_shutdown_input ^ s_q.fpol)) |
    (s_q.cssen & clock_security_fault);

  sync3 u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({external_trigger_input, debug_halt, raw_break}),
    .sync_out(sync_val)
  );
  assign brk_s = sync_val[0];
  assign halt_s = sync_val[1];
  assign trg_s = sync_val[2];

  // safe mode stops the count while the core is halted
  assign frozen = s_q.ctrl[`C_SAFE] & halt_s;
  assign tick = s_q.ctrl[`C_EN] & ~frozen;

  // next state of the whole block
  always_comb begin
    s_d = s_q;
    step = 1'b0;
    ovf = 1'b0;
    unf = 1'b0;
    per_evt = 1'b0;
    upd = 1'b0;
    hw_set = 7'h00;
    // bus write first so that hardware events win afterwards
    if (wr) begin
      if (idx == `IX_DDATA) begin
        s_d = reg_write(s_d, s_q.dbase + s_q.dptr,
          apb_req.pwdata);
        if (s_q.dptr == s_q.dlen)
          s_d.dptr = 4'h0;
        else
          s_d.dptr = s_q.dptr + 4'h1;
      end else begin
        s_d = reg_write(s_d, idx, apb_req.pwdata);
      end
    end
    // read data is captured in the setup phase
    if (apb_req.psel & ~apb_req.penable) begin
      case (idx)
        `IX_CTRL: s_d.prdata = {23'h0, s_q.ctrl};
        `IX_PSC: s_d.prdata = {16'h0, s_q.psc_pre};
        `IX_ARR: s_d.prdata = {16'h0, s_q.arr_pre};
        `IX_REP: s_d.prdata = {24'h0, s_q.rep};
        `IX_CMP0, `IX_CMP1, `IX_CMP2, `IX_CMP3:
          s_d.prdata = {16'h0, s_q.cmp_pre[idx[1:0]]};
        `IX_PROT: s_d.prdata = {17'h0, s_q.cssen, s_q.gate,
          s_q.auto, s_q.fpol, s_q.fen, s_q.lock, s_q.dt};
        `IX_OUT: s_d.prdata = {23'h0, s_q.pol, s_q.idle};
        `IX_STAT: s_d.prdata = {25'h0, s_q.status};
        `IX_IEN: s_d.prdata = {25'h0, s_q.irq_en};
        `IX_CNT: s_d.prdata = {16'h0, s_q.cnt};
        `IX_DCFG: s_d.prdata = {24'h0, s_q.dlen, s_q.dbase};
        default: s_d.prdata = 32'h0000_0000;
      endcase
    end
    // prescaler, one counter step per prescaled period
    if (tick) begin
      if (s_q.psc_cnt >= s_q.psc_act) begin
        s_d.psc_cnt = 16'h0000;
        step = 1'b1;
      end else begin
        s_d.psc_cnt = s_q.psc_cnt + 16'h0001;
      end
    end
    // counter, edge aligned wraps, center aligned turns round
    if (step) begin
      if (!s_q.ctrl[`C_CENTER]) begin
        s_d.dir = pwm_pkg::DIR_UP;
        if (s_q.cnt >= s_q.arr_act) begin
          s_d.cnt = 16'h0000;
          ovf = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + 16'h0001;
        end
      end else if (s_q.dir == pwm_pkg::DIR_UP) begin
        if (s_q.cnt >= s_q.arr_act) begin
          s_d.dir = pwm_pkg::DIR_DOWN;
          s_d.cnt = (s_q.cnt == 16'h0000) ? 16'h0000 :
            s_q.cnt - 16'h0001;
          ovf = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt + 16'h0001;
        end
      end else begin
        if (s_q.cnt == 16'h0000) begin
          s_d.dir = pwm_pkg::DIR_UP;
          s_d.cnt = (s_q.arr_act == 16'h0000) ? 16'h0000 : 16'h0001;
          unf = 1'b1;
        end else begin
          s_d.cnt = s_q.cnt - 16'h0001;
        end
      end
    end
    // period end selection; no bit set falls back to overflow
    if (s_q.ctrl[`C_CENTER])
      per_evt = (ovf & (s_q.ctrl[`C_OVF] | ~s_q.ctrl[`C_UNF])) |
        (unf & s_q.ctrl[`C_UNF]);
    else
      per_evt = ovf;
    // repetition counter, update only when it has run down
    if (per_evt) begin
      if (s_q.rep_cnt == 8'h00) begin
        upd = 1'b1;
        s_d.rep_cnt = s_q.rep;
      end else begin
        s_d.rep_cnt = s_q.rep_cnt - 8'h01;
      end
    end
    // update event moves every preload in the same edge
    if (upd) begin
      s_d.cmp_act = s_d.cmp_pre;
      s_d.arr_act = s_d.arr_pre;
      s_d.psc_act = s_d.psc_pre;
      hw_set[`S_UPD] = 1'b1;
    end
    // compare flags, direction chosen per count direction
    for (int i = 0; i < 4; i++) begin
      if (step && s_q.cnt == s_q.cmp_act[i] &&
          ((s_q.dir == pwm_pkg::DIR_UP && s_q.ctrl[`C_CUP]) ||
           (s_q.dir == pwm_pkg::DIR_DOWN && s_q.ctrl[`C_CDN])))
        hw_set[i + 1] = 1'b1;
    end
    // trigger rising edge sets its flag
    s_d.trg_q = trg_s;
    if (trg_s & ~s_q.trg_q)
      hw_set[`S_TRG] = 1'b1;
    // auto re-enable at update, break always wins over it
    if (upd & s_q.auto)
      s_d.gate = 1'b1;
    if (brk_s) begin
      s_d.gate = 1'b0;
      hw_set[`S_BRK] = 1'b1;
    end
    // set wins over a clear in the same cycle
    s_d.status = s_d.status | hw_set;
    s_d.dma_q = upd & s_q.ctrl[`C_DMA];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.ctrl <= `CTRL_RST;
      s_q.arr_pre <= `ARR_RST;
      s_q.arr_act <= `ARR_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // pwm reference and dead time per complementary pair
  assign dead_w = pwm_pkg::dead_cycles(s_q.dt);
  for (genvar g = 0; g < 3; g++) begin : gen_pair
    assign ref_w[g] = s_q.cnt < s_q.cmp_act[g];
    dead_time_pair u_dead (
      .pclk(pclk),
      .presetn(presetn),
      .ref_in(ref_w[g]),
      .dead(dead_w),
      .high_out(hi_w[g]),
      .low_out(lo_w[g])
    );
    assign pair_out[2 * g] = hi_w[g] ^ s_q.pol[g];
    assign pair_out[2 * g + 1] = lo_w[g] ^ s_q.pol[g];
  end

  // raw pin term keeps the shutdown alive without a clock
  assign force_idle = ~s_q.gate | raw_break | frozen;
  assign pwm_out = force_idle ? s_q.idle : pair_out;
  assign irq = |(s_q.status & s_q.irq_en);
  assign dma_req = s_q.dma_q;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_update_copy: assert property (upd |=>
    s_q.arr_act == $past(s_d.arr_pre) &&
    s_q.cmp_act == $past(s_d.cmp_pre))
    else $error("update did not copy preloads");
  a_direct_cmp: assert property (wr && idx == `IX_CMP1 &&
    !s_q.ctrl[`C_PRELOAD] |=> s_q.cmp_act[1] == $past(apb_req.pwdata[15:0]))
    else $error("direct compare write lost");
  a_rep_divide: assert property (per_evt && s_q.rep_cnt != 8'h00 |->
    !upd ##1 s_q.rep_cnt == $past(s_q.rep_cnt) - 8'h01)
    else $error("update before repetition ran out");
  a_edge_unf: assert property (!s_q.ctrl[`C_CENTER] |-> !unf)
    else $error("underflow in edge mode");
  a_break_gate: assert property (brk_s |=> !s_q.gate &&
    s_q.status[`S_BRK]) else $error("break did not drop gate");
  a_gate_idle: assert property (!s_q.gate |-> pwm_out == s_q.idle)
    else $error("outputs not idle with gate low");
  a_pin_idle: assert property (raw_break |-> pwm_out == s_q.idle)
    else $error("fault pin did not force idle");
  a_lock_once: assert property (s_q.lock_done && wr &&
    idx == `IX_PROT |=> $stable(s_q.lock))
    else $error("lock field rewritten");
  a_auto_back: assert property (s_q.auto && upd && !brk_s |=> s_q.gate)
    else $error("gate not restored at update");
  a_gate_stays: assert property (!s_q.gate && !s_q.auto &&
    !(wr && idx == `IX_PROT) |=> !s_q.gate)
    else $error("gate rose by itself");
  a_freeze_cnt: assert property (frozen |=> $stable(s_q.cnt))
    else $error("counter moved while frozen");
  a_locked_dt: assert property (s_q.lock != `LOCK_OFF |=>
    $stable(s_q.dt)) else $error("dead time changed under lock");

  c_update: cover property (upd ##1 s_q.status[`S_UPD]);
  c_break: cover property (brk_s ##1 !s_q.gate);
  c_center_unf: cover property (unf && per_evt);
  c_burst: cover property (wr && idx == `IX_DDATA ##1
    wr && idx == `IX_DDATA);
endmodule

// ### tb/inverter_stage_model.sv
// Purpose: power stage and fault sensor stand-in for the pwm timer
// Assumes: pair g drives pwm_out[2g] high side, pwm_out[2g+1] low side
// Notes: counts shoot-through and measures the pair 0 off gap
`timescale 1ns/100ps
module inverter_stage_model (
  input wire logic pclk,
  input wire logic [5:0] pwm_out,
  input wire logic fault_cmd,
  input wire logic css_cmd,
  output logic fault_shutdown_input,
  output logic clock_security_fault,
  output logic [31:0] shoot_count,
  output logic [31:0] last_gap
);
  logic [31:0] gap_q;
  // sensors report active high, levels follow the bench commands
  assign fault_shutdown_input = fault_cmd;
  assign clock_security_fault = css_cmd;
  initial begin
    shoot_count = 32'h0;
    last_gap = 32'h0;
    gap_q = 32'h0;
  end
  // sampled mid-cycle because pwm_out settles after the rising edge
  always @(negedge pclk) begin
    for (int g = 0; g < 3; g++) begin
      if (pwm_out[2*g] && pwm_out[2*g+1]) begin
        shoot_count <= shoot_count + 32'h1;
      end
    end
    if (pwm_out[1:0] === 2'b00) begin
      gap_q <= gap_q + 32'h1;
    end else begin
      if (gap_q != 32'h0) begin
        last_gap <= gap_q;
      end
      gap_q <= 32'h0;
    end
  end
endmodule

// ### tb/testbench.sv
// Purpose: self-checking bench for the motor pwm timer
// Assumes: apb slave answers in its own time, every wait is bounded
// Notes: random counts come from a fixed seed, corner cases by hand
`timescale 1ns/100ps
module testbench;
  logic pclk;
  logic presetn;
  pwm_pkg::apb_req_type req;
  pwm_pkg::apb_rsp_type rsp;
  logic fault_cmd, css_cmd, debug_halt, trig, fault_in, css_in;
  logic dma_req, irq, err;
  logic [5:0] pwm_out, idle;
  logic [31:0] shoot_count, last_gap, rd, c1;
  logic [15:0] a, p;
  logic [7:0] r, c;
  logic [7:0] modes [4] = '{8'h00, 8'h06, 8'h0A, 8'h0E};
  int fail_count, checks_done, n;

  motor_pwm_timer_protect dut (.pclk(pclk), .presetn(presetn),
    .apb_req(req), .apb_rsp(rsp), .fault_shutdown_input(fault_in),
    .clock_security_fault(css_in), .debug_halt(debug_halt),
    .external_trigger_input(trig), .pwm_out(pwm_out), .irq(irq),
    .dma_req(dma_req));
  inverter_stage_model stage (.pclk(pclk), .pwm_out(pwm_out),
    .fault_cmd(fault_cmd), .css_cmd(css_cmd),
    .fault_shutdown_input(fault_in), .clock_security_fault(css_in),
    .shoot_count(shoot_count), .last_gap(last_gap));

  // 125 MHz clock
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic timeout();
    fail_count++;
    $display("CHECK FAILED t=%0t wait ran out got=%h exp=%h", $time, 0, 1);
    print_verdict();
  endtask
  // one apb transfer, request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] ad,
      input logic [31:0] wd);
    int i;
    @(posedge pclk);
    req.psel <= 1'b1;
    req.penable <= 1'b0;
    req.pwrite <= w;
    req.paddr <= ad;
    req.pwdata <= wd;
    @(posedge pclk);
    req.penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (rsp.pready === 1'b1) break;
    end
    if (i == 16) timeout();
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    apb(1'b1, ad, wd);
  endtask
  task automatic rdr(input logic [7:0] ad);
    apb(1'b0, ad, 32'h0);
  endtask
  // cycles until the next update pulse, bounded
  task automatic wait_dma(input int lim, output int cnt);
    for (cnt = 1; cnt <= lim; cnt++) begin
      @(negedge pclk);
      if (dma_req === 1'b1) return;
    end
    timeout();
  endtask
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  function automatic logic [31:0] exp_upd(input logic [7:0] m,
      input logic [15:0] a, input logic [15:0] p, input logic [7:0] r);
    logic [31:0] st;
    st = (m == 8'h0) ? a + 32'h1 : (m == 8'hE) ? {16'h0, a} : 32'h2 * a;
    return st * (p + 32'h1) * (r + 32'h1);
  endfunction
  // off gap is the dead count plus the one forced low cycle
  function automatic logic [31:0] exp_gap(input logic [7:0] g);
    if (!g[7]) return {25'h0, g[6:0]} + 32'h1;
    return ({26'h0, g[5:0]} + 32'h40) * 32'h2 + 32'h1;
  endfunction
  // idle levels never switch both sides of a pair on
  function automatic logic [5:0] pick_idle();
    return {2'($urandom % 3), 2'($urandom % 3), 2'($urandom % 3)};
  endfunction

  initial begin
    req = '0;
    presetn = 1'b0;
    fault_cmd = 1'b0;
    css_cmd = 1'b0;
    debug_halt = 1'b0;
    trig = 1'b0;
    fail_count = 0;
    checks_done = 0;
    void'($urandom(32'hEA65368B));
    do_reset();
    rdr(8'h00);
    chk(rd, 32'h190);
    rdr(8'h08);
    chk(rd, 32'hFFFF);
    chk({26'h0, pwm_out}, 32'h0);
    rdr(8'h3C);
    chk({31'h0, err}, 32'h1);
    // trigger pulse sets its flag
    trig <= 1'b1;
    repeat (2) @(posedge pclk);
    trig <= 1'b0;
    repeat (5) @(posedge pclk);
    rdr(8'h28);
    chk({31'h0, rd[6]}, 32'h1);
    // first update still uses the reset period
    wr(8'h08, 32'h8);
    wr(8'h00, 32'hD1);
    wait_dma(70000, n);
    for (int k = 0; k < 4; k++) begin
      a = 16'h4 + 16'($urandom % 12);
      p = 16'($urandom % 3);
      r = 8'($urandom % 4);
      wr(8'h08, {16'h0, a});
      wr(8'h04, {16'h0, p});
      wr(8'h0C, {24'h0, r});
      repeat (2) wait_dma(2000, n);
      wr(8'h00, 32'hD1 | {24'h0, modes[k]});
      repeat (3) wait_dma(2000, n);
      chk(32'(n), exp_upd(modes[k], a, p, r));
    end
    // dead time on pair 0, zero code and a coarse code included
    wr(8'h04, 32'h0);
    wr(8'h0C, 32'h0);
    wr(8'h08, 32'h12C);
    wr(8'h10, 32'h96);
    wr(8'h00, 32'hD1);
    for (int k = 0; k < 3; k++) begin
      c = (k == 2) ? 8'h81 : (k == 1) ? 8'h0 : 8'($urandom % 20 + 1);
      wr(8'h20, 32'h2000 | {24'h0, c});
      repeat (3) wait_dma(1000, n);
      chk(last_gap, exp_gap(c));
    end
    // fault pin break, outputs go idle at once
    idle = pick_idle();
    wr(8'h24, {26'h0, idle});
    wr(8'h2C, 32'h20);
    wr(8'h20, 32'h2C00);
    @(posedge pclk);
    fault_cmd <= 1'b1;
    #1;
    chk({26'h0, pwm_out}, {26'h0, idle});
    repeat (6) @(posedge pclk);
    rdr(8'h20);
    chk({31'h0, rd[13]}, 32'h0);
    rdr(8'h28);
    chk({31'h0, rd[5]}, 32'h1);
    chk({31'h0, irq}, 32'h1);
    fault_cmd <= 1'b0;
    repeat (6) @(posedge pclk);
    rdr(8'h20);
    chk({31'h0, rd[13]}, 32'h0);
    chk({26'h0, pwm_out}, {26'h0, idle});
    wr(8'h28, 32'h20);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0);
    // automatic re-enable, pulse placed just after an update
    wr(8'h20, 32'h3C00);
    wait_dma(1000, n);
    @(posedge pclk);
    fault_cmd <= 1'b1;
    repeat (5) @(posedge pclk);
    fault_cmd <= 1'b0;
    repeat (5) @(posedge pclk);
    rdr(8'h20);
    chk({31'h0, rd[13]}, 32'h0);
    wait_dma(1000, n);
    repeat (2) @(posedge pclk);
    rdr(8'h20);
    chk({31'h0, rd[13]}, 32'h1);
    // clock monitor as second break source
    wr(8'h20, 32'h6000);
    css_cmd <= 1'b1;
    repeat (6) @(posedge pclk);
    rdr(8'h20);
    chk({31'h0, rd[13]}, 32'h0);
    css_cmd <= 1'b0;
    // let the synchronised break run out so the gate write below sticks
    repeat (6) @(posedge pclk);
    // safe debug freezes, normal debug keeps counting
    wr(8'h20, 32'h2000);
    wr(8'h00, 32'hF1);
    debug_halt <= 1'b1;
    repeat (6) @(posedge pclk);
    rdr(8'h30);
    c1 = rd;
    rdr(8'h30);
    chk(rd, c1);
    chk({26'h0, pwm_out}, {26'h0, idle});
    debug_halt <= 1'b0;
    repeat (6) @(posedge pclk);
    rdr(8'h30);
    chk({31'h0, rd !== c1}, 32'h1);
    wr(8'h00, 32'hD1);
    debug_halt <= 1'b1;
    repeat (2) wait_dma(1000, n);
    chk(32'(n), 32'd301);
    @(posedge pclk);
    debug_halt <= 1'b0;
    chk(shoot_count, 32'h0);
    // lock level one after a fresh reset
    do_reset();
    wr(8'h20, 32'h0112);
    wr(8'h20, 32'h2234);
    rdr(8'h20);
    chk(rd, 32'h2112);
    wr(8'h24, 32'h1FF);
    rdr(8'h24);
    chk(rd, 32'h1C0);
    // preload off: burst words reach the active compares at once
    p = 16'($urandom) | 16'h0001;
    a = 16'($urandom);
    wr(8'h00, 32'h180);
    wr(8'h34, 32'h14);
    wr(8'h38, 32'h5A5A);
    wr(8'h38, {16'h0, a});
    wr(8'h38, {16'h0, p});
    repeat (30) @(posedge pclk);
    chk({30'h0, pwm_out[1:0]}, 32'h2);
    rdr(8'h10);
    chk(rd, {16'h0, p});
    rdr(8'h14);
    chk(rd, {16'h0, a});
    print_verdict();
  end
endmodule
